/* File: rp_pkg.sv */
// rp_pkg: constants and types for the remote payload packer
package rp_pkg;
    localparam int ADDR_W = 8;
    localparam int LEN_W = 8;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_INSTAT_SEL = 8'h04;
    localparam logic [7:0] OFF_TEST_SEL = 8'h08;
    localparam logic [7:0] OFF_MON_SEL = 8'h0C;
    localparam logic [7:0] OFF_TAG_COUNT = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [1:0] TAG_REGION = 2'h1; // addr[7:6], tag table at 0x40..0x7F
    // control register fields
    localparam int CTRL_START = 0;
    localparam int CTRL_GEN_EN = 1;
    localparam int CTRL_OUTSTAT_EN = 2;
    localparam int CTRL_MONOUT_EN = 3;
    // status register fields
    localparam int STAT_BUSY = 0;
    localparam int STAT_START_PEND = 1;
    localparam int STAT_LEN_LSB = 8;
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] SEL_RST = 32'h0000_0000;
    localparam logic [31:0] TAG_VALUE_RST = 32'h0000_0000;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {TAG_BOOL, TAG_BYTE, TAG_WORD, TAG_DWORD} rp_tag_kind_t;

    typedef struct packed {
        logic first;
        logic last;
        logic [7:0] data;
    } rp_beat_t;
endpackage : rp_pkg

/* File: rp_axil_slave.sv */
// rp_axil_slave: AXI4-Lite handshake front end turning bus traffic into register strobes
`timescale 1ns/1ps
module rp_axil_slave (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // write address and data
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [rp_pkg::ADDR_W-1:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // read address and data
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [rp_pkg::ADDR_W-1:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // register side
    output logic o_wr_en,
    output logic [rp_pkg::ADDR_W-1:0] o_wr_addr,
    output logic [31:0] o_wr_data,
    output logic [3:0] o_wr_strb,
    input wire logic i_wr_err,
    output logic o_rd_en,
    output logic [rp_pkg::ADDR_W-1:0] o_rd_addr,
    input wire logic [31:0] i_rd_data,
    input wire logic i_rd_err
);
    // both halves held and no response outstanding: commit exactly once
    assign o_wr_en = ~o_awready & ~o_wready & ~o_bvalid;

    // write path; address and data are taken in either order
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_awready <= 1'b1;
            o_wready <= 1'b1;
            o_bvalid <= 1'b0;
            o_bresp <= rp_pkg::RESP_OKAY;
            o_wr_addr <= '0;
            o_wr_data <= '0;
            o_wr_strb <= '0;
        end else begin
            if (i_awvalid && o_awready) begin
                o_awready <= 1'b0;
                o_wr_addr <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                o_wready <= 1'b0;
                o_wr_data <= i_wdata;
                o_wr_strb <= i_wstrb;
            end
            if (o_wr_en) begin
                o_bvalid <= 1'b1;
                o_bresp <= i_wr_err ? rp_pkg::RESP_SLVERR : rp_pkg::RESP_OKAY;
            end
            if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
                o_awready <= 1'b1;
                o_wready <= 1'b1;
            end
        end
    end

    // read path; data is sampled one cycle after the address is taken
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_arready <= 1'b1;
            o_rd_en <= 1'b0;
            o_rd_addr <= '0;
            o_rvalid <= 1'b0;
            o_rdata <= '0;
            o_rresp <= rp_pkg::RESP_OKAY;
        end else begin
            o_rd_en <= i_arvalid && o_arready;
            if (i_arvalid && o_arready) begin
                o_arready <= 1'b0;
                o_rd_addr <= i_araddr;
            end
            if (o_rd_en) begin
                o_rvalid <= 1'b1;
                o_rdata <= i_rd_data;
                o_rresp <= i_rd_err ? rp_pkg::RESP_SLVERR : rp_pkg::RESP_OKAY;
            end
            if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
                o_arready <= 1'b1;
            end
        end
    end
endmodule : rp_axil_slave

/* File: rp_payload_packer.sv */
// rp_payload_packer: builds the remote input payload byte stream from status, monitor and tags
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module rp_payload_packer #(
    parameter int N_IN = 5,
    parameter int N_TEST = 2,
    parameter int N_TAG = 8,
    parameter bit LEGACY = 1'b0
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // AXI4-Lite register bus
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [rp_pkg::ADDR_W-1:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [rp_pkg::ADDR_W-1:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // status and monitor sources, same clock
    input wire logic [7:0] i_gen_status,
    input wire logic [8*N_IN-1:0] i_in_status,
    input wire logic [7:0] i_out_status,
    input wire logic [8*N_TEST-1:0] i_test_status,
    input wire logic [8*N_IN-1:0] i_in_monitor,
    input wire logic [7:0] i_out_monitor,
    // frame trigger from device logic
    input wire logic i_send,
    // payload byte stream toward the network master
    output rp_pkg::rp_beat_t o_tx_beat,
    output logic o_tx_valid,
    input wire logic i_tx_ready,
    output logic [rp_pkg::LEN_W-1:0] o_frame_len,
    output logic o_busy
);
    localparam int S = 2 * N_IN + N_TEST + 3;
    localparam int SLOT_W = $clog2(S);
    localparam int TAG_W = $clog2(N_TAG);
    localparam int TCNT_W = $clog2(N_TAG + 1);
    localparam logic [SLOT_W-1:0] SLOT_LAST = SLOT_W'(S - 1);

    typedef enum logic [1:0] {ST_IDLE, ST_SLOTS, ST_TAGS} rp_state_t;

    // register side of the bus front end
    logic wr_en;
    logic [rp_pkg::ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic rd_en;
    logic [rp_pkg::ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;
    logic wr_err;
    logic rd_err;

    // software registers
    logic [31:0] ctrl;
    logic [N_IN-1:0] instat_sel;
    logic [N_TEST-1:0] test_sel;
    logic [N_IN-1:0] mon_sel;
    logic [TCNT_W-1:0] tag_count;
    logic [1:0] tag_kind [N_TAG];
    logic [31:0] tag_value [N_TAG];
    logic start_pend;

    // framer state
    rp_state_t state;
    logic [SLOT_W-1:0] slot;
    logic [TAG_W-1:0] tag_idx;
    logic [1:0] tag_byte;
    logic [rp_pkg::LEN_W-1:0] sent;
    logic [8*S-1:0] snap_bytes;
    logic [S-1:0] snap_en;
    logic [TCNT_W-1:0] snap_tags;

    rp_axil_slave u_bus (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_awvalid(i_awvalid),
        .o_awready(o_awready),
        .i_awaddr(i_awaddr),
        .i_wvalid(i_wvalid),
        .o_wready(o_wready),
        .i_wdata(i_wdata),
        .i_wstrb(i_wstrb),
        .o_bvalid(o_bvalid),
        .i_bready(i_bready),
        .o_bresp(o_bresp),
        .i_arvalid(i_arvalid),
        .o_arready(o_arready),
        .i_araddr(i_araddr),
        .o_rvalid(o_rvalid),
        .i_rready(i_rready),
        .o_rdata(o_rdata),
        .o_rresp(o_rresp),
        .o_wr_en(wr_en),
        .o_wr_addr(wr_addr),
        .o_wr_data(wr_data),
        .o_wr_strb(wr_strb),
        .i_wr_err(wr_err),
        .o_rd_en(rd_en),
        .o_rd_addr(rd_addr),
        .i_rd_data(rd_data),
        .i_rd_err(rd_err)
    );

    // address decode, shared by reads and writes
    wire logic [31:0] wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire logic [31:0] wmerge_ctrl = (ctrl & ~wmask) | (wr_data & wmask);
    wire logic w_ctrl = wr_en && wr_addr == rp_pkg::OFF_CTRL;
    wire logic w_insel = wr_en && wr_addr == rp_pkg::OFF_INSTAT_SEL;
    wire logic w_testsel = wr_en && wr_addr == rp_pkg::OFF_TEST_SEL;
    wire logic w_monsel = wr_en && wr_addr == rp_pkg::OFF_MON_SEL;
    wire logic w_tcount = wr_en && wr_addr == rp_pkg::OFF_TAG_COUNT;
    wire logic [TAG_W-1:0] w_tag_idx = wr_addr[TAG_W+2:3];
    // index compared one bit wider, a 3-bit table size of eight would wrap to zero
    wire logic w_tag_hit = wr_addr[7:6] == rp_pkg::TAG_REGION && 4'(wr_addr[5:3]) < 4'(N_TAG);
    wire logic w_tag = wr_en && w_tag_hit && wr_addr[1:0] == 2'h0;
    wire logic [TAG_W-1:0] r_tag_idx = rd_addr[TAG_W+2:3];
    wire logic r_tag_hit = rd_addr[7:6] == rp_pkg::TAG_REGION && 4'(rd_addr[5:3]) < 4'(N_TAG);
    wire logic [31:0] r_tag_word = rd_addr[2] ? tag_value[r_tag_idx] : {30'h0, tag_kind[r_tag_idx]};
    wire logic w_known = wr_addr == rp_pkg::OFF_CTRL || wr_addr == rp_pkg::OFF_INSTAT_SEL
        || wr_addr == rp_pkg::OFF_TEST_SEL || wr_addr == rp_pkg::OFF_MON_SEL
        || wr_addr == rp_pkg::OFF_TAG_COUNT || wr_addr == rp_pkg::OFF_STATUS
        || (w_tag_hit && wr_addr[1:0] == 2'h0);
    // status is read only; a write there is answered but changes nothing
    assign wr_err = ~w_known;
    assign rd_err = ~(r_tag_hit && rd_addr[1:0] == 2'h0) && rd_data == 32'h0
        && rd_addr != rp_pkg::OFF_CTRL && rd_addr != rp_pkg::OFF_INSTAT_SEL
        && rd_addr != rp_pkg::OFF_TEST_SEL && rd_addr != rp_pkg::OFF_MON_SEL
        && rd_addr != rp_pkg::OFF_TAG_COUNT && rd_addr != rp_pkg::OFF_STATUS;

    // read mux; start bit reads back zero since it is a command, not a setting
    wire logic [31:0] r_status = {16'h0, o_frame_len, 6'h0, start_pend, o_busy};
    assign rd_data = (rd_addr == rp_pkg::OFF_CTRL) ? {ctrl[31:1], 1'b0} :
        (rd_addr == rp_pkg::OFF_INSTAT_SEL) ? 32'(instat_sel) :
        (rd_addr == rp_pkg::OFF_TEST_SEL) ? 32'(test_sel) :
        (rd_addr == rp_pkg::OFF_MON_SEL) ? 32'(mon_sel) :
        (rd_addr == rp_pkg::OFF_TAG_COUNT) ? 32'(tag_count) :
        (rd_addr == rp_pkg::OFF_STATUS) ? r_status :
        (r_tag_hit && rd_addr[1:0] == 2'h0) ? r_tag_word : 32'h0;

    // configuration registers; monitor fields stay zero in the older variant
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            ctrl <= rp_pkg::CTRL_RST;
            instat_sel <= N_IN'(rp_pkg::SEL_RST);
            test_sel <= N_TEST'(rp_pkg::SEL_RST);
            mon_sel <= N_IN'(rp_pkg::SEL_RST);
            tag_count <= '0;
        end else begin
            if (w_ctrl) begin
                ctrl <= {wmerge_ctrl[31:4], wmerge_ctrl[3] & ~LEGACY, wmerge_ctrl[2:1], 1'b0};
            end
            if (w_insel && wr_strb[0]) begin
                instat_sel <= wr_data[N_IN-1:0];
            end
            if (w_testsel && wr_strb[0]) begin
                test_sel <= wr_data[N_TEST-1:0];
            end
            if (w_monsel && wr_strb[0]) begin
                mon_sel <= LEGACY ? '0 : wr_data[N_IN-1:0];
            end
            if (w_tcount && wr_strb[0]) begin
                // counts above the table size are clamped so the walk never overruns
                tag_count <= (wr_data[7:0] > 8'(N_TAG)) ? TCNT_W'(N_TAG) : wr_data[TCNT_W-1:0];
            end
        end
    end

    // tag table in registration order: kind then value per entry
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            for (int i = 0; i < N_TAG; i++) begin
                tag_kind[i] <= rp_pkg::TAG_BOOL;
                tag_value[i] <= rp_pkg::TAG_VALUE_RST;
            end
        end else if (w_tag) begin
            if (!wr_addr[2]) begin
                if (wr_strb[0]) begin
                    tag_kind[w_tag_idx] <= wr_data[1:0];
                end
            end else begin
                tag_value[w_tag_idx] <= (tag_value[w_tag_idx] & ~wmask) | (wr_data & wmask);
            end
        end
    end

    // size of one tag in bytes
    function automatic logic [2:0] tag_size(input logic [1:0] kind);
        unique case (kind)
            rp_pkg::TAG_WORD: tag_size = 3'h2;
            rp_pkg::TAG_DWORD: tag_size = 3'h4;
            default: tag_size = 3'h1;
        endcase
    endfunction : tag_size

    // slot order fixes the layout: status first, then monitor
    wire logic mon_allowed = ~LEGACY;
    wire logic [S-1:0] live_en = {ctrl[rp_pkg::CTRL_MONOUT_EN] & mon_allowed,
        mon_sel & {N_IN{mon_allowed}},
        test_sel,
        ctrl[rp_pkg::CTRL_OUTSTAT_EN],
        instat_sel,
        ctrl[rp_pkg::CTRL_GEN_EN]};
    wire logic [8*S-1:0] live_bytes = {i_out_monitor, i_in_monitor, i_test_status,
        i_out_status, i_in_status, i_gen_status};

    // total length: enabled slots plus sizes of registered tags
    logic [rp_pkg::LEN_W-1:0] live_len;
    always_comb begin
        live_len = '0;
        for (int i = 0; i < S; i++) begin
            live_len = live_len + rp_pkg::LEN_W'(live_en[i]);
        end
        for (int i = 0; i < N_TAG; i++) begin
            if (TCNT_W'(i) < tag_count) begin
                live_len = live_len + rp_pkg::LEN_W'(tag_size(tag_kind[i]));
            end
        end
    end

    // stream control
    wire logic adv = ~o_tx_valid | i_tx_ready;
    wire logic slot_hit = snap_en[slot];
    wire logic [7:0] slot_byte = snap_bytes[8*slot +: 8];
    wire logic [31:0] cur_tag = tag_value[tag_idx];
    wire logic [2:0] cur_size = tag_size(tag_kind[tag_idx]);
    wire logic tag_end = 3'(tag_byte) == cur_size - 3'h1;
    wire logic last_tag = TCNT_W'(tag_idx) == snap_tags - TCNT_W'(1);
    wire logic emit = adv && ((state == ST_SLOTS && slot_hit) || state == ST_TAGS);
    wire logic [7:0] emit_byte = (state == ST_TAGS) ? cur_tag[8*tag_byte +: 8] : slot_byte;

    // a send request waits here; a new one in the take cycle is kept
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            start_pend <= 1'b0;
        end else begin
            start_pend <= (w_ctrl && wr_strb[0] && wr_data[rp_pkg::CTRL_START]) || i_send
                || (start_pend && (state != ST_IDLE || o_tx_valid));
        end
    end

    // frame walk: one slot or one tag byte per accepted cycle
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            state <= ST_IDLE;
            slot <= '0;
            tag_idx <= '0;
            tag_byte <= '0;
            snap_bytes <= '0;
            snap_en <= '0;
            snap_tags <= '0;
            o_frame_len <= '0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    // the previous last beat must leave first so its length stays valid
                    if (start_pend && !o_tx_valid) begin
                        // inputs are frozen so one frame is self consistent
                        snap_bytes <= live_bytes;
                        snap_en <= live_en;
                        snap_tags <= tag_count;
                        o_frame_len <= live_len;
                        slot <= '0;
                        tag_idx <= '0;
                        tag_byte <= '0;
                        state <= ST_SLOTS;
                    end
                end
                ST_SLOTS: begin
                    // disabled slots are skipped, so nothing is reserved for them
                    if (adv) begin
                        slot <= slot + SLOT_W'(1);
                        if (slot == SLOT_LAST) begin
                            state <= (snap_tags == '0) ? ST_IDLE : ST_TAGS;
                        end
                    end
                end
                ST_TAGS: begin
                    if (adv) begin
                        tag_byte <= tag_end ? 2'h0 : tag_byte + 2'h1;
                        if (tag_end) begin
                            tag_idx <= tag_idx + TAG_W'(1);
                            if (last_tag) begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // output beat register, low byte of a multi-byte tag first
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_tx_valid <= 1'b0;
            o_tx_beat <= '0;
            sent <= '0;
        end else if (emit) begin
            o_tx_valid <= 1'b1;
            o_tx_beat.data <= emit_byte;
            o_tx_beat.first <= sent == '0;
            o_tx_beat.last <= sent == o_frame_len - rp_pkg::LEN_W'(1);
            sent <= (sent == o_frame_len - rp_pkg::LEN_W'(1)) ? '0 : sent + rp_pkg::LEN_W'(1);
        end else if (adv) begin
            o_tx_valid <= 1'b0;
        end
    end

    // busy until the final beat has been taken
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_busy <= 1'b0;
        end else begin
            o_busy <= start_pend || state != ST_IDLE || (o_tx_valid && !i_tx_ready) || emit;
        end
    end
endmodule : rp_payload_packer

/* File: rp_packer_sva.sv */
// rp_packer_sva: framing and handshake assertions for the payload packer
`timescale 1ns/1ps
module rp_packer_sva (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // register bus handshakes
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic o_bvalid,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic o_rvalid,
    // payload stream
    input wire logic i_send,
    input wire rp_pkg::rp_beat_t o_tx_beat,
    input wire logic o_tx_valid,
    input wire logic i_tx_ready,
    input wire logic [rp_pkg::LEN_W-1:0] o_frame_len,
    input wire logic o_busy
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    logic take;
    logic [7:0] n_taken;
    assign take = o_tx_valid && i_tx_ready;
    // beats taken so far in this frame; cleared on the last one so frames never blur
    always_ff @(posedge i_clock) begin
        if (!i_nrst) n_taken <= 8'h00;
        else if (take) n_taken <= o_tx_beat.last ? 8'h00 : n_taken + 8'h01;
    end
    chk_beat_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_beat))
        else $error("beat changed while stalled");
    chk_valid_busy: assert property (o_tx_valid |-> o_busy)
        else $error("beat offered while idle");
    chk_count_last: assert property (take && o_tx_beat.last |-> n_taken + 8'h01 == o_frame_len)
        else $error("last beat at wrong count");
    chk_first_slot: assert property (take && o_tx_beat.first |-> n_taken == 8'h00)
        else $error("first flag not on byte zero");
    chk_len_steady: assert property (o_tx_valid && $past(o_tx_valid) |-> $stable(o_frame_len))
        else $error("frame length moved mid frame");
    chk_send_busy: assert property (i_send |-> ##[1:2] o_busy)
        else $error("request did not raise busy");
    chk_last_gap: assert property (take && o_tx_beat.last |=> !o_tx_valid)
        else $error("beat offered right after last");
    chk_wr_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready
        |-> ##2 o_bvalid)
        else $error("write answer late");
    chk_rd_answer: assert property (i_arvalid && o_arready |-> ##2 o_rvalid)
        else $error("read answer late");
endmodule : rp_packer_sva

bind rp_payload_packer rp_packer_sva u_sva (.*);

/* File: rp_net_master.sv */
// rp_net_master: network master model taking payload beats, optionally stalling
`timescale 1ns/1ps
module rp_net_master (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // payload stream
    input wire rp_pkg::rp_beat_t i_beat,
    input wire logic i_valid,
    output logic o_ready,
    // stall every other cycle when high
    input wire logic i_stall
);
    rp_pkg::rp_beat_t got[$];
    // alternating ready makes the packer hold beats, as a busy master would
    always @(posedge i_clock) begin
        if (!i_nrst) begin
            o_ready <= 1'b0;
        end else begin
            o_ready <= i_stall ? !o_ready : 1'b1;
            if (i_valid && o_ready) got.push_back(i_beat);
        end
    end
endmodule : rp_net_master

/* File: remote_io_payload_packer_tb_top.sv */
// remote_io_payload_packer_tb_top: register-driven frame tests for the payload packer
`timescale 1ns/1ps
module remote_io_payload_packer_tb_top;
    localparam logic [1:0] OK = rp_pkg::RESP_OKAY;
    logic i_clock, i_nrst, i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready;
    logic i_arvalid, o_arready, o_rvalid, i_rready, i_send, o_tx_valid, i_tx_ready, o_busy, stall;
    logic [7:0] i_awaddr, i_araddr, i_gen_status, i_out_status, i_out_monitor, o_frame_len;
    logic [31:0] i_wdata, o_rdata, rd, old_rdata;
    logic [3:0] i_wstrb;
    logic [1:0] o_bresp, o_rresp;
    logic [39:0] i_in_status, i_in_monitor;
    logic [15:0] i_test_status;
    logic [119:0] src;
    logic [7:0] exp_q[$];
    rp_pkg::rp_beat_t o_tx_beat;
    int n_fail, num_checks;
    // all status and monitor sources come from one rotating pattern
    assign {i_gen_status, i_in_status, i_out_status, i_test_status, i_in_monitor} = src[119:8];
    assign i_out_monitor = src[7:0];
    rp_payload_packer #(.LEGACY(1'b0)) dut (.*);
    // older variant sharing the bus stimulus; only its read data is looked at
    rp_payload_packer #(.LEGACY(1'b1)) dut_old (.*, .o_awready(), .o_wready(), .o_bvalid(),
        .o_bresp(), .o_arready(), .o_rvalid(), .o_rdata(old_rdata), .o_rresp(), .o_tx_beat(),
        .o_tx_valid(), .o_frame_len(), .o_busy());
    rp_net_master u_master (.i_clock(i_clock), .i_nrst(i_nrst), .i_beat(o_tx_beat),
        .i_valid(o_tx_valid), .o_ready(i_tx_ready), .i_stall(stall));
    initial begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, want, seen);
        end
    endtask : chk
    task automatic final_report;
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    // one write; address and data released each when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
        @(posedge i_clock);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        do begin
            @(posedge i_clock);
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
        end while (!o_bvalid);
        i_bready <= 1'b0;
        chk("bresp", 32'(o_bresp), 32'(resp));
    endtask : wr
    task automatic rdr(input logic [7:0] a, input logic [1:0] resp);
        @(posedge i_clock);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do begin
            @(posedge i_clock);
            if (o_arready) i_arvalid <= 1'b0;
        end while (!o_rvalid);
        i_rready <= 1'b0;
        rd = o_rdata;
        chk("rresp", 32'(o_rresp), 32'(resp));
    endtask : rdr
    // configure, build the expected layout, send one frame (two when reps > 1) and compare every byte
    task automatic run(input logic [3:0] ctrl, input logic [4:0] isel, input logic [1:0] tsel,
        input logic [4:0] msel, input int nt, input logic [7:0] kinds, input int reps);
        logic [31:0] v;
        int n;
        src <= {src[111:0], src[119:112]};
        wr(rp_pkg::OFF_INSTAT_SEL, 32'(isel), OK);
        wr(rp_pkg::OFF_TEST_SEL, 32'(tsel), OK);
        wr(rp_pkg::OFF_MON_SEL, 32'(msel), OK);
        wr(rp_pkg::OFF_TAG_COUNT, 32'(nt), OK);
        exp_q = {};
        if (ctrl[1]) exp_q.push_back(i_gen_status);
        for (int k = 0; k < 5; k++) if (isel[k]) exp_q.push_back(i_in_status[8*k+:8]);
        if (ctrl[2]) exp_q.push_back(i_out_status);
        for (int k = 0; k < 2; k++) if (tsel[k]) exp_q.push_back(i_test_status[8*k+:8]);
        for (int k = 0; k < 5; k++) if (msel[k]) exp_q.push_back(i_in_monitor[8*k+:8]);
        if (ctrl[3]) exp_q.push_back(i_out_monitor);
        for (int t = 0; t < nt; t++) begin
            v = 32'h8765_4321 ^ (t * 32'h1111_1111);
            wr(8'h40 + 8'(8 * t), 32'(kinds[2*t+:2]), OK);
            wr(8'h44 + 8'(8 * t), v, OK);
            n = kinds[2*t+:2] == rp_pkg::TAG_DWORD ? 4 : kinds[2*t+:2] == rp_pkg::TAG_WORD ? 2 : 1;
            for (int b = 0; b < n; b++) exp_q.push_back(v[8*b+:8]);
        end
        wr(rp_pkg::OFF_CTRL, 32'(ctrl), OK);
        u_master.got = {};
        i_send <= 1'b1;
        @(posedge i_clock);
        i_send <= 1'b0;
        if (reps > 1) wr(rp_pkg::OFF_CTRL, 32'(ctrl) | 32'h1, OK);
        repeat (400) begin
            @(posedge i_clock);
            if (!o_busy && u_master.got.size() >= exp_q.size() * reps) break;
        end
        chk("frame_len", 32'(o_frame_len), exp_q.size());
        chk("byte count", u_master.got.size(), exp_q.size() * reps);
        foreach (u_master.got[j]) begin
            chk("byte", 32'(u_master.got[j].data), 32'(exp_q[j % exp_q.size()]));
            chk("first", 32'(u_master.got[j].first), 32'(j % exp_q.size() == 0));
            chk("last", 32'(u_master.got[j].last), 32'(j % exp_q.size() == exp_q.size() - 1));
        end
        rdr(rp_pkg::OFF_STATUS, OK);
        chk("status", rd & 32'h0000_FF03, 32'(exp_q.size()) << 8);
    endtask : run
    initial begin
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_send, stall} = '0;
        {i_awaddr, i_araddr, i_wdata} = '0;
        i_wstrb = 4'hF;
        src = 120'hA1_1514131211_B2_C4C3_D5D4D3D2D1_E6;
        i_nrst = 1'b0;
        repeat (10) @(posedge i_clock);
        i_nrst <= 1'b1;
        // reset value, unmapped place, monitor section present in this variant
        rdr(rp_pkg::OFF_CTRL, OK);
        chk("ctrl reset", rd, rp_pkg::CTRL_RST);
        rdr(8'h20, rp_pkg::RESP_SLVERR);
        chk("unmapped read", rd, 32'h0);
        wr(8'h20, 32'hFFFF_FFFF, rp_pkg::RESP_SLVERR);
        wr(rp_pkg::OFF_MON_SEL, 32'h1F, OK);
        rdr(rp_pkg::OFF_MON_SEL, OK);
        chk("monitor select", rd, 32'h1F);
        chk("old monitor select", old_rdata, 32'h0);
        // sparse inputs and monitors with output monitor, then bool and byte tags
        run(4'hC, 5'h15, 2'h0, 5'h15, 2, 8'h04, 1);
        // general, output, both test and first two input status bytes, no monitor, all tag kinds, stalled master, repeated request
        stall <= 1'b1;
        run(4'h6, 5'h03, 2'h3, 5'h00, 4, 8'hE4, 2);
        // no general status, bool then double word tag
        run(4'h4, 5'h03, 2'h0, 5'h00, 2, 8'h0C, 1);
        final_report();
    end
    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge i_clock);
        n_fail++;
        final_report();
    end
endmodule : remote_io_payload_packer_tb_top
